// File: rtl/cbcra_top.sv
// Processor board clocks, reset distribution and auto-jump bus sequencer
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - Processor clock and phase-2 clock: 125 ns high every 250 ns.
// - Phase-1 clock 75 ns (62 ns rounded up to 3 cycles) every 250 ns; half-rate clock low 250 ns per 500 ns.
// - Bus reset low holds processor reset and power-on-clear low; release follows.
// - After reset exactly one forced jump; next fetch addresses the jumper target.
// - Bus ready low stalls via wait, starting at the first fetch after the jump.
// - While stalled in a fetch, fetch status stays high and address stays stable.
// - Undriven data-in reads all ones, so restart-7 executes repeatedly.
// - Each restart-7 calls 0038; those fetched at 0038 push return 0039 as bytes 00 then 39.
// - Loop lasts 2.75 us: one 500 ns fetch pulse, two 250 ns write strobes.
// - Any 16-bit address is selectable as jump target from static header pins.
// - 4 MHz from the fast source; slow strap gives 2 MHz operation.
module cbcra_top (
    input  wire logic        clock,
    input  wire logic        rstn,
    input  wire logic        bus_reset_n,
    input  wire logic        bus_ready,
    input  wire logic [7:0]  data_in,
    input  wire logic [15:0] power_on_jump_header,
    input  wire logic        half_speed_strap,
    output var  logic        cpu_clock,
    output var  logic        phase2_clock,
    output var  logic        phase1_clock,
    output var  logic        half_rate_bus_clock_n,
    output var  logic        cpu_reset_n,
    output var  logic        power_on_clear_n,
    output var  logic        cpu_wait_n,
    output var  logic        cpu_int_n,
    output var  logic        cpu_nmi_n,
    output var  logic [15:0] address,
    output var  logic [7:0]  data_out,
    output var  logic        opcode_fetch_n,
    output var  logic        status_m1,
    output var  logic        bus_write_out_n
);
    import cbcra_pkg::*;

    logic [SYNC_W-1:0] sync1_reg;
    logic [SYNC_W-1:0] sync2_reg;
    logic              bus_reset_s;
    logic              ready_s;
    logic              slow_s;
    logic [7:0]        din_s;
    logic [15:0]       hdr_s;
    logic              cpu_tick;
    logic              cpu_clock_w;

    cbcra_state_t      state_reg;
    logic [2:0]        tcnt_reg;
    logic [2:0]        tlast_reg;
    logic              waiting_reg;
    logic [15:0]       pc_reg;
    logic [15:0]       sp_reg;
    logic [15:0]       ret_reg;
    logic [15:0]       addr_reg;
    logic [7:0]        wdata_reg;
    logic [7:0]        byte_reg;
    logic [7:0]        lo_reg;
    logic              rd_hi_reg;
    logic              wr_lo_reg;
    logic [1:0]        jump_idx_reg;
    logic              jump_done_reg;
    logic [7:0]        forced_byte;
    logic [7:0]        rd_byte;
    logic              at_sample;
    logic              wait_req;

    // All pin inputs except clock and rstn pass two flip-flops
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            sync1_reg <= SYNC_RESET;
            sync2_reg <= SYNC_RESET;
        end
        else
        begin
            sync1_reg <= {bus_reset_n, bus_ready, half_speed_strap, data_in,
                          power_on_jump_header};
            sync2_reg <= sync1_reg;
        end
    end

    assign bus_reset_s = sync2_reg[26];
    assign ready_s     = sync2_reg[25];
    assign slow_s      = sync2_reg[24];
    assign din_s       = sync2_reg[23:16];
    assign hdr_s       = sync2_reg[15:0];

    cbcra_clkgen u_clkgen (
        .clock                 (clock),
        .rstn                  (rstn),
        .slow_mode             (slow_s),
        .cpu_clock             (cpu_clock_w),
        .phase1_clock          (phase1_clock),
        .half_rate_bus_clock_n (half_rate_bus_clock_n),
        .cpu_tick              (cpu_tick)
    );

    assign cpu_clock    = cpu_clock_w;
    assign phase2_clock = cpu_clock_w;
    assign cpu_int_n    = 1'b1;
    assign cpu_nmi_n    = 1'b1;

    // Jump opcode then header low and high bytes replace data-in
    always_comb
    begin
        unique case (jump_idx_reg)
            2'h0:    forced_byte = OP_JUMP;
            2'h1:    forced_byte = hdr_s[7:0];
            2'h2:    forced_byte = hdr_s[15:8];
            default: forced_byte = OP_JUMP;
        endcase
    end

    assign rd_byte   = jump_done_reg ? din_s : forced_byte;
    assign at_sample = tcnt_reg == T_SAMPLE;
    assign wait_req  = !ready_s && jump_done_reg;

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn || !bus_reset_s)
        begin
            state_reg     <= st_fetch;
            tcnt_reg      <= T_FIRST;
            tlast_reg     <= T_FETCH;
            waiting_reg   <= 1'b0;
            pc_reg        <= PC_RESET;
            sp_reg        <= SP_RESET;
            ret_reg       <= PC_RESET;
            addr_reg      <= PC_RESET;
            wdata_reg     <= 8'h00;
            byte_reg      <= 8'h00;
            lo_reg        <= 8'h00;
            rd_hi_reg     <= 1'b0;
            wr_lo_reg     <= 1'b0;
            jump_idx_reg  <= 2'h0;
            jump_done_reg <= 1'b0;
        end
        else if (cpu_tick)
        begin
            if (at_sample && wait_req)
            begin
                waiting_reg <= 1'b1;
            end
            else
            begin
                waiting_reg <= 1'b0;
                if (at_sample && state_reg != st_write)
                begin
                    byte_reg <= rd_byte;
                    pc_reg   <= pc_reg + 16'h0001;
                    if (!jump_done_reg)
                        jump_idx_reg <= jump_idx_reg + 2'h1;
                    if (state_reg == st_fetch && rd_byte == OP_RST7)
                        tlast_reg <= T_FETCH_RST;
                end
                if (tcnt_reg != tlast_reg)
                begin
                    tcnt_reg <= tcnt_reg + 3'h1;
                end
                else
                begin
                    tcnt_reg <= T_FIRST;
                    unique case (state_reg)
                        st_fetch:
                        begin
                            if (byte_reg == OP_JUMP)
                            begin
                                state_reg <= st_read;
                                rd_hi_reg <= 1'b0;
                                addr_reg  <= pc_reg;
                                tlast_reg <= T_MEM;
                            end
                            else if (byte_reg == OP_RST7)
                            begin
                                state_reg <= st_write;
                                ret_reg   <= pc_reg;
                                sp_reg    <= sp_reg - 16'h0001;
                                addr_reg  <= sp_reg - 16'h0001;
                                wdata_reg <= pc_reg[15:8];
                                wr_lo_reg <= 1'b0;
                                tlast_reg <= T_MEM;
                            end
                            else
                            begin
                                addr_reg  <= pc_reg;
                                tlast_reg <= T_FETCH;
                            end
                        end
                        st_read:
                        begin
                            if (!rd_hi_reg)
                            begin
                                lo_reg    <= byte_reg;
                                rd_hi_reg <= 1'b1;
                                addr_reg  <= pc_reg;
                            end
                            else
                            begin
                                pc_reg        <= {byte_reg, lo_reg};
                                addr_reg      <= {byte_reg, lo_reg};
                                state_reg     <= st_fetch;
                                tlast_reg     <= T_FETCH;
                                jump_done_reg <= 1'b1;
                            end
                        end
                        st_write:
                        begin
                            if (!wr_lo_reg)
                            begin
                                sp_reg    <= sp_reg - 16'h0001;
                                addr_reg  <= sp_reg - 16'h0001;
                                wdata_reg <= ret_reg[7:0];
                                wr_lo_reg <= 1'b1;
                            end
                            else
                            begin
                                pc_reg    <= RST7_VECTOR;
                                addr_reg  <= RST7_VECTOR;
                                state_reg <= st_fetch;
                                tlast_reg <= T_FETCH;
                            end
                        end
                        default:
                        begin
                            state_reg <= st_fetch;
                        end
                    endcase
                end
            end
        end
    end

    // Bus and processor pins, one clock behind the sequencer
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            cpu_reset_n      <= 1'b0;
            power_on_clear_n <= 1'b0;
            cpu_wait_n       <= 1'b1;
            address          <= 16'h0000;
            data_out         <= 8'h00;
            opcode_fetch_n   <= 1'b1;
            status_m1        <= 1'b0;
            bus_write_out_n  <= 1'b1;
        end
        else
        begin
            cpu_reset_n      <= bus_reset_s;
            power_on_clear_n <= bus_reset_s;
            cpu_wait_n       <= !waiting_reg;
            address          <= addr_reg;
            data_out         <= wdata_reg;
            opcode_fetch_n   <= !(bus_reset_s && state_reg == st_fetch && tcnt_reg <= T_SAMPLE);
            status_m1        <= bus_reset_s && state_reg == st_fetch;
            bus_write_out_n  <= !(bus_reset_s && state_reg == st_write && at_sample);
        end
    end

    reset_hold_a : assert property (
        @(posedge clock) disable iff (!rstn)
        $fell(bus_reset_s) |=> !cpu_reset_n && !power_on_clear_n && !status_m1
    ) else $error("bus reset did not hold processor reset and power-on-clear low");

    jump_target_a : assert property (
        @(posedge clock) disable iff (!rstn || !bus_reset_s)
        $rose(jump_done_reg) |-> state_reg == st_fetch && addr_reg == hdr_s ##2 address == hdr_s
    ) else $error("first fetch after jump not at header address");

    one_jump_a : assert property (
        @(posedge clock) disable iff (!rstn || !bus_reset_s)
        jump_done_reg |=> jump_done_reg && jump_idx_reg == 2'h3
    ) else $error("forced jump repeated without reset");

    forced_nowait_a : assert property (
        @(posedge clock) disable iff (!rstn)
        !jump_done_reg |-> !waiting_reg
    ) else $error("wait inserted during the forced jump");

    stall_fetch_a : assert property (
        @(posedge clock) disable iff (!rstn || !bus_reset_s)
        cpu_tick && jump_done_reg && state_reg == st_fetch && at_sample && !ready_s
            |=> waiting_reg ##1 !cpu_wait_n
    ) else $error("bus ready low did not stall the fetch");

    stall_hold_a : assert property (
        @(posedge clock) disable iff (!rstn || !bus_reset_s)
        waiting_reg && $past(waiting_reg) && state_reg == st_fetch
            |-> status_m1 && !opcode_fetch_n && $stable(address)
    ) else $error("fetch status or address moved while stalled");

    rst_exec_a : assert property (
        @(posedge clock) disable iff (!rstn || !bus_reset_s)
        cpu_tick && jump_done_reg && state_reg == st_fetch && at_sample && ready_s
            && din_s == 8'hff |-> ##[1:80] state_reg == st_write
    ) else $error("all-ones opcode did not start a restart push");

    push_bytes_a : assert property (
        @(posedge clock) disable iff (!rstn || !bus_reset_s)
        $rose(state_reg == st_write) |-> wdata_reg == ret_reg[15:8]
            && addr_reg == $past(sp_reg) - 16'h0001
    ) else $error("first pushed byte or stack address wrong");

    rst_vector_a : assert property (
        @(posedge clock) disable iff (!rstn || !bus_reset_s)
        $fell(state_reg == st_write) |-> pc_reg == RST7_VECTOR && $past(wdata_reg) == ret_reg[7:0]
    ) else $error("restart did not call 0038 after low byte push");

    write_strobe_a : assert property (
        @(posedge clock) disable iff (!rstn || !bus_reset_s || !ready_s || slow_s)
        $fell(bus_write_out_n) |-> !bus_write_out_n [*5] ##1 !bus_write_out_n [*5]
            ##1 bus_write_out_n
    ) else $error("write strobe not 250 ns");
endmodule : cbcra_top
`default_nettype wire

// File: rtl/cbcra_pkg.sv
// Shared constants and types for the processor board control logic
package cbcra_pkg;
    localparam int SYS_PERIOD_NS  = 25;
    localparam int CPU_PERIOD_NS  = 250;
    localparam int CPU_HIGH_NS    = 125;
    localparam int PH1_WIDTH_NS   = 62;
    localparam int CPU_PERIOD_CYC = CPU_PERIOD_NS / SYS_PERIOD_NS;
    localparam int CPU_HIGH_CYC   = CPU_HIGH_NS / SYS_PERIOD_NS;
    localparam int PH1_WIDTH_CYC  = (PH1_WIDTH_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
    localparam int SLOW_FACTOR    = 2;

    localparam logic [7:0]  OP_JUMP     = 8'hc3;
    localparam logic [7:0]  OP_RST7     = 8'hff;
    localparam logic [15:0] RST7_VECTOR = 16'h0038;
    localparam logic [15:0] PC_RESET    = 16'h0000;
    localparam logic [15:0] SP_RESET    = 16'hffff;

    localparam logic [2:0]  T_FIRST     = 3'h1;
    localparam logic [2:0]  T_SAMPLE    = 3'h2;
    localparam logic [2:0]  T_MEM       = 3'h3;
    localparam logic [2:0]  T_FETCH     = 3'h4;
    localparam logic [2:0]  T_FETCH_RST = 3'h5;

    localparam int          SYNC_W      = 27;
    localparam logic [26:0] SYNC_RESET  = 27'h2ff0000;

    typedef enum logic [1:0] {
        st_fetch = 2'h0,
        st_read  = 2'h1,
        st_write = 2'h2
    } cbcra_state_t;
endpackage : cbcra_pkg

// File: rtl/cbcra_clkgen.sv
// Processor and bus clock generator with 2 MHz fallback
`timescale 1ns/100ps
`default_nettype none
module cbcra_clkgen #(
    parameter int PERIOD_CYC = cbcra_pkg::CPU_PERIOD_CYC,
    parameter int HIGH_CYC   = cbcra_pkg::CPU_HIGH_CYC,
    parameter int PH1_CYC    = cbcra_pkg::PH1_WIDTH_CYC
) (
    input  wire logic clock,
    input  wire logic rstn,
    input  wire logic slow_mode,
    output var  logic cpu_clock,
    output var  logic phase1_clock,
    output var  logic half_rate_bus_clock_n,
    output var  logic cpu_tick
);
    import cbcra_pkg::*;

    localparam int CW = $clog2(PERIOD_CYC * SLOW_FACTOR + 1);

    if (HIGH_CYC < 1 || PH1_CYC < 1 || HIGH_CYC + PH1_CYC > PERIOD_CYC)
    begin : g_bad_timing
        $error("cbcra_clkgen: clock pulse widths do not fit the period");
    end

    logic [CW-1:0] cnt_reg;
    logic [CW-1:0] cnt_next;
    logic [CW-1:0] last_cnt;
    logic [CW-1:0] high_cnt;
    logic [CW-1:0] ph1_end;

    // Slow strap doubles every count
    assign last_cnt = slow_mode ? CW'(PERIOD_CYC * SLOW_FACTOR - 1) : CW'(PERIOD_CYC - 1);
    assign high_cnt = slow_mode ? CW'(HIGH_CYC * SLOW_FACTOR) : CW'(HIGH_CYC);
    assign ph1_end  = slow_mode ? CW'((HIGH_CYC + PH1_CYC) * SLOW_FACTOR) : CW'(HIGH_CYC + PH1_CYC);

    always_comb
    begin
        cnt_next = (cnt_reg >= last_cnt) ? '0 : cnt_reg + CW'(1);
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            cnt_reg <= CW'(PERIOD_CYC - 1);
        else
            cnt_reg <= cnt_next;
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            cpu_clock    <= 1'b0;
            phase1_clock <= 1'b0;
            cpu_tick     <= 1'b0;
        end
        else
        begin
            cpu_clock    <= cnt_next < high_cnt;
            phase1_clock <= cnt_next >= high_cnt && cnt_next < ph1_end;
            cpu_tick     <= cnt_next == '0;
        end
    end

    // Fast: toggle on each processor period; slow: low while the processor clock is high
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            half_rate_bus_clock_n <= 1'b1;
        else if (slow_mode)
            half_rate_bus_clock_n <= !(cnt_next < high_cnt);
        else if (cnt_next == '0)
            half_rate_bus_clock_n <= !half_rate_bus_clock_n;
    end

    cpu_clock_shape_a : assert property (
        @(posedge clock) disable iff (!rstn || slow_mode)
        $rose(cpu_clock) |-> cpu_clock [*5] ##1 !cpu_clock [*5] ##1 cpu_clock
    ) else $error("processor clock pulse or period wrong");

    phase1_width_a : assert property (
        @(posedge clock) disable iff (!rstn || slow_mode)
        $rose(phase1_clock) |-> !cpu_clock && phase1_clock [*3] ##1 !phase1_clock
    ) else $error("phase-1 pulse width wrong");

    half_rate_a : assert property (
        @(posedge clock) disable iff (!rstn || slow_mode)
        $fell(half_rate_bus_clock_n) |-> $rose(cpu_clock) ##9 !half_rate_bus_clock_n
            ##1 half_rate_bus_clock_n ##9 half_rate_bus_clock_n ##1 !half_rate_bus_clock_n
    ) else $error("half-rate clock not low 250 ns every 500 ns");
endmodule : cbcra_clkgen
`default_nettype wire

// File: sim/cbcra_backplane.sv
// Backplane model: reset switch, ready line and an otherwise empty data-in bus
`timescale 1ns/100ps
`default_nettype none
module cbcra_backplane (
    input  wire logic       switch_pressed,
    input  wire logic       hold_ready,
    output var  logic       bus_reset_n,
    output var  logic       bus_ready,
    output var  logic [7:0] data_in
);
    // Reset switch pulls the bus reset line low while pressed
    assign bus_reset_n = !switch_pressed;
    // Ready strapped to ground stalls the processor
    assign bus_ready   = !hold_ready;
    // No board drives data-in, so the pull-ups win
    assign data_in     = 8'hff;
endmodule : cbcra_backplane
`default_nettype wire

// File: sim/tb_cbcra_top.sv
// Self-checking bench for the processor board control logic
`timescale 1ns/100ps
`default_nettype none
module tb_cbcra_top;
    logic        clock;
    logic        rstn;
    logic        switch_pressed;
    logic        hold_ready;
    logic        half_speed_strap;
    logic [15:0] jump_header;
    wire logic        bus_reset_n, bus_ready, cpu_clock, phase2_clock, phase1_clock;
    wire logic        half_rate_bus_clock_n, cpu_reset_n, power_on_clear_n, cpu_wait_n;
    wire logic        cpu_int_n, cpu_nmi_n, opcode_fetch_n, status_m1, bus_write_out_n;
    wire logic [7:0]  data_in, data_out;
    wire logic [15:0] address;
    int          num_errors;
    int          n_compared;

    cbcra_backplane u_bp (
        .switch_pressed (switch_pressed),
        .hold_ready     (hold_ready),
        .bus_reset_n    (bus_reset_n),
        .bus_ready      (bus_ready),
        .data_in        (data_in)
    );

    cbcra_top u_dut (
        .clock                 (clock),
        .rstn                  (rstn),
        .bus_reset_n           (bus_reset_n),
        .bus_ready             (bus_ready),
        .data_in               (data_in),
        .power_on_jump_header  (jump_header),
        .half_speed_strap      (half_speed_strap),
        .cpu_clock             (cpu_clock),
        .phase2_clock          (phase2_clock),
        .phase1_clock          (phase1_clock),
        .half_rate_bus_clock_n (half_rate_bus_clock_n),
        .cpu_reset_n           (cpu_reset_n),
        .power_on_clear_n      (power_on_clear_n),
        .cpu_wait_n            (cpu_wait_n),
        .cpu_int_n             (cpu_int_n),
        .cpu_nmi_n             (cpu_nmi_n),
        .address               (address),
        .data_out              (data_out),
        .opcode_fetch_n        (opcode_fetch_n),
        .status_m1             (status_m1),
        .bus_write_out_n       (bus_write_out_n)
    );

    initial
    begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    task automatic check_value(input string what, input logic [15:0] seen,
                               input logic [15:0] expected);
        n_compared++;
        if (seen !== expected)
        begin
            num_errors++;
            $display("FAIL %s expected %h seen %h", what, expected, seen);
        end
    endtask : check_value

    function automatic logic pick(input int i);
        case (i)
            0:       return cpu_clock;
            1:       return phase2_clock;
            2:       return phase1_clock;
            3:       return half_rate_bus_clock_n;
            4:       return opcode_fetch_n;
            default: return bus_write_out_n;
        endcase
    endfunction : pick

    // Width of the next pulse at level lvl and its full period, in system cycles
    task automatic measure(input int i, input logic lvl, output int width, output int period);
        int n;
        n = 0;
        while (pick(i) === lvl && n < 400) begin @(negedge clock); n++; end
        n = 0;
        while (pick(i) !== lvl && n < 400) begin @(negedge clock); n++; end
        width = 0;
        while (pick(i) === lvl && width < 400) begin @(negedge clock); width++; end
        period = width;
        while (pick(i) !== lvl && period < 400) begin @(negedge clock); period++; end
    endtask : measure

    task automatic check_pulse(input string what, input int i, input logic lvl,
                               input int exp_w, input int exp_p);
        int w;
        int p;
        measure(i, lvl, w, p);
        check_value({what, " width"}, 16'(w), 16'(exp_w));
        check_value({what, " period"}, 16'(p), 16'(exp_p));
    endtask : check_pulse

    task automatic test_clocks;
        logic prev_cpu;
        logic prev_half;
        check_pulse("cpu_clock", 0, 1'b1, 5, 10);
        check_pulse("phase2_clock", 1, 1'b1, 5, 10);
        check_pulse("phase1_clock", 2, 1'b1, 3, 10);
        check_pulse("half_rate_bus_clock_n", 3, 1'b0, 10, 20);
        // Half-rate clock must change at every processor clock rise
        prev_cpu = cpu_clock;
        prev_half = half_rate_bus_clock_n;
        repeat (40)
        begin
            @(negedge clock);
            if (prev_cpu === 1'b0 && cpu_clock === 1'b1)
                check_value("half clock aligned", 16'(half_rate_bus_clock_n), 16'(!prev_half));
            prev_cpu = cpu_clock;
            prev_half = half_rate_bus_clock_n;
        end
        $display("test clocks done");
    endtask : test_clocks

    task automatic test_reset;
        switch_pressed = 1'b1;
        repeat (5) @(negedge clock);
        check_value("cpu_reset_n held", 16'(cpu_reset_n), 16'h0000);
        check_value("power_on_clear_n held", 16'(power_on_clear_n), 16'h0000);
        check_value("int idle", 16'({cpu_int_n, cpu_nmi_n}), 16'h0003);
        switch_pressed = 1'b0;
        repeat (5) @(negedge clock);
        check_value("cpu_reset_n released", 16'(cpu_reset_n), 16'h0001);
        check_value("power_on_clear_n released", 16'(power_on_clear_n), 16'h0001);
        $display("test reset done");
    endtask : test_reset

    task automatic test_autojump;
        int n;
        n = 0;
        while (!(status_m1 === 1'b1 && address === jump_header) && n < 600)
        begin
            @(negedge clock);
            n++;
        end
        check_value("jump target reached", 16'(n < 600), 16'h0001);
        repeat (30) @(negedge clock);
        repeat (50)
        begin
            @(negedge clock);
            check_value("stalled address", address, jump_header);
            check_value("stalled fetch status", 16'(status_m1), 16'h0001);
            check_value("stalled wait", 16'(cpu_wait_n), 16'h0000);
        end
        hold_ready = 1'b0;
        $display("test autojump done");
    endtask : test_autojump

    task automatic test_restart_loop;
        int n;
        int strobes;
        logic prev_w;
        n = 0;
        while (!(opcode_fetch_n === 1'b0 && address === 16'h0038) && n < 600)
        begin
            @(negedge clock);
            n++;
        end
        check_value("restart vector fetched", 16'(n < 600), 16'h0001);
        check_pulse("opcode_fetch_n", 4, 1'b0, 20, 110);
        // One full loop from the fetch fall: two pushes, 00 then 39
        strobes = 0;
        prev_w = bus_write_out_n;
        repeat (110)
        begin
            @(negedge clock);
            check_value("wait idle in loop", 16'(cpu_wait_n), 16'h0001);
            if (prev_w === 1'b1 && bus_write_out_n === 1'b0)
            begin
                check_value("pushed byte", 16'(data_out), strobes == 0 ? 16'h0000 : 16'h0039);
                strobes++;
            end
            prev_w = bus_write_out_n;
        end
        check_value("strobes per loop", 16'(strobes), 16'h0002);
        check_pulse("bus_write_out_n", 5, 1'b0, 10, 30);
        $display("test restart loop done");
    endtask : test_restart_loop

    task automatic test_slow;
        half_speed_strap = 1'b1;
        rstn = 1'b0;
        repeat (2) @(negedge clock);
        rstn = 1'b1;
        check_pulse("slow cpu_clock", 0, 1'b1, 10, 20);
        check_pulse("slow half clock", 3, 1'b0, 10, 20);
        $display("test slow done");
    endtask : test_slow

    task automatic complete_run;
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : complete_run

    initial
    begin
        num_errors = 0;
        n_compared = 0;
        rstn = 1'b0;
        // Bus reset released at start so the later press lands mid-run
        switch_pressed = 1'b0;
        hold_ready = 1'b1;
        half_speed_strap = 1'b0;
        // Arbitrary target, every nibble distinct
        jump_header = 16'he8a5;
        repeat (2) @(negedge clock);
        rstn = 1'b1;
        test_clocks();
        test_reset();
        test_autojump();
        test_restart_loop();
        test_slow();
        complete_run();
    end

    initial
    begin
        #(25 * 20000);
        num_errors++;
        $display("FAIL watchdog expected completion seen timeout");
        complete_run();
    end
endmodule : tb_cbcra_top
`default_nettype wire
